// *** hw/ccs_pkg.sv ***
/*
  package for the charge cycle sequencer: register offsets, field positions,
  reset values, timing counts, state codes and carrier structs.
  assumes a single 25 mhz clock domain.
*/
package ccs_pkg;
  // clock rate and timing
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned TICK_MS = 1;
  localparam int unsigned TICK_CYCLES = (CLK_HZ / 1000) * TICK_MS;
  localparam int unsigned SHIP_DLY_S = 10;
  localparam int unsigned EVENT_US = 256;
  localparam int unsigned EVENT_CYCLES = (CLK_HZ / 1000000) * EVENT_US;
  localparam int unsigned LOWBAT_HOURS = 2;
  localparam int unsigned MS_PER_HOUR = 3600000;

  // register offsets
  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_TIMER = 4'h1;
  localparam logic [3:0] OFF_STATUS = 4'h2;
  localparam logic [3:0] OFF_FAULT = 4'h3;

  // control register fields
  localparam int CTRL_CHG_EN = 0;
  localparam int CTRL_TERM_EN = 1;
  localparam int CTRL_TMR_EN = 2;
  localparam int CTRL_SLOW_EN = 3;
  localparam int CTRL_WARM_V = 4;
  localparam int CTRL_COOL_I = 5;
  localparam int CTRL_SW_OFF = 6;
  localparam int CTRL_SHIP_DLY = 7;
  localparam int CTRL_REG_RST = 8;
  localparam int CTRL_BOOST_HOT_THRESHOLD_SELECT_LO = 9;
  localparam logic [9:0] CTRL_RESET = 10'h00f;
  localparam logic [7:0] TIMER_RESET = 8'h42; // fast timer 4, top-off 2

  // status codes
  localparam logic [1:0] PHASE_OFF = 2'h0;
  localparam logic [1:0] PHASE_PRE = 2'h1;
  localparam logic [1:0] PHASE_FAST = 2'h2;
  localparam logic [1:0] PHASE_DONE = 2'h3;
  localparam logic [1:0] FAULT_TIMER = 2'h3;
  localparam logic [1:0] FAULT_NONE = 2'h0;
  localparam logic [2:0] SRC_NONE = 3'h0;
  localparam logic [2:0] SRC_BOOST = 3'h7;
  localparam logic [1:0] BOOST_HOT_THRESHOLD_SELECT_OFF = 2'h3;

  typedef enum logic [1:0] {
    CCS_IDLE = 2'b00,
    CCS_CHARGE = 2'b01,
    CCS_TOPOFF = 2'b10,
    CCS_DONE = 2'b11
  } ccs_state_t;

  // analog comparator results sampled by the sequencer
  typedef struct packed {
    logic bat_short;    // below 2.2 v
    logic bat_low;      // below 3 v
    logic bat_lowv;     // below low-battery threshold
    logic above_rechg;  // above recharge threshold
    logic below_iterm;  // current below termination
    logic vdpm;         // input voltage regulation
    logic idpm;         // input current regulation
    logic therm;        // thermal regulation
    logic ts_in_range;  // thermistor within coldest/hottest
    logic ts_cool;
    logic ts_warm;
    logic ts_boost_ok;  // within boost window
    logic fault;        // other charge fault
  } ccs_sense_t;

  // drive outputs to the analog side
  typedef struct packed {
    logic charge_on;
    logic bat_switch_on;
    logic warm_limit_41;
    logic cool_cut_20;
    logic cool_cut_half;
    logic boost_run;
    logic short_current;
  } ccs_drive_t;
endpackage : ccs_pkg

// *** hw/ccs_tick_gen.sv ***
/*
  prescaler giving the timer tick for the safety and top-off timers.
  assumes the clock enable freezes it with the rest of the block.
*/
`timescale 1ns/100ps
module ccs_tick_gen #(
  parameter int unsigned DIV = ccs_pkg::TICK_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_ce,
  input wire logic i_slow,
  output logic o_tick
);
  import ccs_pkg::*;

  initial begin
    if (DIV < 2) $error("ccs_tick_gen: DIV must be at least 2");
  end

  typedef struct packed {
    logic [31:0] cnt;
    logic half;
  } ccs_tick_st_t;

  ccs_tick_st_t st_reg;
  ccs_tick_st_t st_next;

  // wrap counter; every wrap ticks, or every second wrap when slowed
  always_comb begin
    st_next = st_reg;
    o_tick = 1'b0;
    if (st_reg.cnt == DIV - 1) begin
      st_next.cnt = 32'h0;
      st_next.half = ~st_reg.half;
      o_tick = ~i_slow | st_reg.half; // R24
    end else begin
      st_next.cnt = st_reg.cnt + 32'h1;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      st_reg <= '0;
    end else if (i_ce) begin
      st_reg <= st_next;
    end
  end
endmodule : ccs_tick_gen

// *** hw/ccs_pulse.sv ***
/*
  stretches a one-cycle event into a fixed-width event pulse for the host.
  assumes events closer than the pulse width merge into one pulse.
*/
`timescale 1ns/100ps
module ccs_pulse #(
  parameter int unsigned WIDTH = ccs_pkg::EVENT_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_ce,
  input wire logic i_event,
  output logic o_pulse
);
  import ccs_pkg::*;

  initial begin
    if (WIDTH < 1 || WIDTH > 65535) $error("ccs_pulse: WIDTH must be 1 to 65535");
  end

  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;

  // reload on event, count down otherwise
  always_comb begin
    if (i_event) cnt_next = 16'(WIDTH);
    else if (cnt_reg != 16'h0) cnt_next = cnt_reg - 16'h1;
    else cnt_next = cnt_reg;
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      cnt_reg <= 16'h0;
    end else if (i_ce) begin
      cnt_reg <= cnt_next;
    end
  end

  assign o_pulse = (cnt_reg != 16'h0);
endmodule : ccs_pulse

// *** hw/ccs_sequencer.sv ***
/*
  charge cycle sequencer: phase selection, termination, top-off timer,
  safety timer, temperature zone limits, boost thermistor monitor and
  battery switch shipping delay, with a small register port for the host.
  assumes comparator inputs synchronous to i_clk.

// What this block does
// (R1) pick short/precharge (01) or fast (10) from battery voltage at cycle start
// (R2) overload or thermal regulation blocks termination and halves the safety timer
// (R3) end cycle at voltage above recharge and current below termination; open switch
// (R4) termination sets phase code 11 and pulses the host event
// (R5) termination enable bit cleared prevents termination
// (R6) top-off timer runs after termination, pauses and slows with the safety timer
// (R7) readable flag shows the top-off timer running
// (R8) top-off timer clears on charge enable rise, termination rise, defaults restore
// (R9) top-off duration latched at termination; new writes apply at recharge
// (R10) event pulse at top-off start and at top-off expiry
// (R11) charge only while thermistor in range; suspend outside, resume inside
// (R12) warm zone limits voltage to regulation or 4.1 v by select bit
// (R13) cool zone cuts current, select bit allows 20 percent
// (R14) boost outside window: suspend boost, source code 000, thermistor fault flag
// (R15) boost hot select 11 reports the fault but keeps boost running
// (R16) safety limit is 2 hours below low battery, programmed setting otherwise
// (R17) safety expiry sets charge fault code 11 and pulses the host event
// (R18) safety timer enable cleared stops safety enforcement
// (R19) regulation or cool zone halves safety rate unless slowdown enable is 0
// (R20) safety timer pauses during fault, clears on charge disable and re-enable
// (R21) input voltage and current limit flags follow overload regulation
// (R22) switch off bit opens switch at once or after shipping delay
// (R23) phase code 00 off, 01 precharge, 10 fast or cv, 11 done
// (R24) timer ticks from a prescaler, every second tick when slowed
// (R25) phase re-evaluated continuously as battery voltage crosses thresholds
*/
// Design decisions made here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
module ccs_sequencer #(
  parameter int unsigned TICK_DIV = ccs_pkg::TICK_CYCLES,
  parameter int unsigned LOWBAT_TICKS = ccs_pkg::LOWBAT_HOURS * ccs_pkg::MS_PER_HOUR,
  parameter int unsigned HOUR_TICKS = ccs_pkg::MS_PER_HOUR,
  parameter int unsigned TOPOFF_UNIT_TICKS = ccs_pkg::MS_PER_HOUR / 4,
  parameter int unsigned SHIP_TICKS = ccs_pkg::SHIP_DLY_S * 1000,
  parameter int unsigned EVENT_WIDTH = ccs_pkg::EVENT_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_ce,
  input wire logic i_enable_pin_n,
  input wire logic i_boost_req,
  input wire ccs_pkg::ccs_sense_t i_sense,
  input wire logic [3:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  output ccs_pkg::ccs_drive_t o_drive,
  output logic [1:0] o_charge_phase_code,
  output logic [2:0] o_input_source_code,
  output logic o_event
);
  import ccs_pkg::*;

  initial begin
    if (TICK_DIV < 2 || LOWBAT_TICKS < 1 || HOUR_TICKS < 1 || TOPOFF_UNIT_TICKS < 1 || SHIP_TICKS < 1) begin
      $error("ccs_sequencer: timer parameters must be positive");
    end
  end

  typedef struct packed {
    ccs_state_t fsm;
    logic [9:0] ctrl;          // control bits
    logic [7:0] timer_cfg;     // [7:4] fast timer hours, [1:0] top-off units
    logic [1:0] topoff_sel;    // latched top-off duration
    logic [31:0] safety_cnt;
    logic [31:0] topoff_cnt;
    logic [31:0] ship_cnt;
    logic ship_wait;
    logic switch_open_ship;
    logic [1:0] phase;
    logic [1:0] fault_code;
    logic safety_expired;      // blocks restart until disable and re-enable
    logic thermistor_fault_flag;
    logic chg_allowed_d;
    logic [15:0] rdata;
  } ccs_st_t;

  ccs_st_t st_reg;
  ccs_st_t st_next;
  logic tick;
  logic slow;
  logic ev_term;
  logic ev_top_start;
  logic ev_top_end;
  logic ev_safety;
  logic chg_allowed;
  logic regulating;
  logic term_ok;
  logic safety_limit_hit;
  logic topoff_done;
  logic safety_paused;
  logic [31:0] safety_limit;
  logic [31:0] topoff_limit;
  logic boost_oor;

  // phase from battery voltage thresholds
  function automatic logic [1:0] phase_of(input ccs_sense_t s);
    phase_of = s.bat_low ? PHASE_PRE : PHASE_FAST; // R1 R23
  endfunction : phase_of

  // top-off duration in ticks, zero selects no top-off
  function automatic logic [31:0] topoff_ticks(input logic [1:0] sel);
    topoff_ticks = 32'(sel) * 32'(TOPOFF_UNIT_TICKS); // R9
  endfunction : topoff_ticks

  assign slow = st_reg.ctrl[CTRL_SLOW_EN] & (i_sense.vdpm | i_sense.idpm | i_sense.therm | i_sense.ts_cool); // R19
  assign regulating = i_sense.vdpm | i_sense.idpm | i_sense.therm; // R2

  ccs_tick_gen #(.DIV(TICK_DIV)) u_tick (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_ce(i_ce),
    .i_slow(slow),
    .o_tick(tick)
  );

  ccs_pulse #(.WIDTH(EVENT_WIDTH)) u_pulse (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_ce(i_ce),
    .i_event(ev_term | ev_top_start | ev_top_end | ev_safety),
    .o_pulse(o_event)
  );

  // charging allowed by enable pin and enable bit
  assign chg_allowed = st_reg.ctrl[CTRL_CHG_EN] & ~i_enable_pin_n;
  assign term_ok = st_reg.ctrl[CTRL_TERM_EN] & ~regulating & i_sense.above_rechg & i_sense.below_iterm; // R2 R3 R5
  assign safety_limit = i_sense.bat_lowv ? 32'(LOWBAT_TICKS)
                        : 32'(st_reg.timer_cfg[7:4]) * 32'(HOUR_TICKS); // R16
  assign safety_limit_hit = st_reg.safety_cnt >= safety_limit;
  assign topoff_limit = topoff_ticks(st_reg.topoff_sel);
  assign topoff_done = st_reg.topoff_cnt >= topoff_limit;
  assign safety_paused = i_sense.fault | ~i_sense.ts_in_range; // R20
  assign boost_oor = i_boost_req & ~i_sense.ts_boost_ok;

  // sequencer next state
  always_comb begin
    st_next = st_reg;
    ev_term = 1'b0;
    ev_top_start = 1'b0;
    ev_top_end = 1'b0;
    ev_safety = 1'b0;
    st_next.chg_allowed_d = chg_allowed;

    // host writes; restore defaults clears config and top-off timer
    if (i_wr) begin
      unique case (i_addr)
        OFF_CTRL: st_next.ctrl = i_wdata[9:0];
        OFF_TIMER: st_next.timer_cfg = i_wdata[7:0];
        default: ;
      endcase
    end
    if (st_next.ctrl[CTRL_REG_RST]) begin
      st_next.ctrl = CTRL_RESET;
      st_next.timer_cfg = TIMER_RESET;
      st_next.topoff_cnt = 32'h0; // R8
    end

    // reading the fault register releases the latched code
    if (i_rd && i_addr == OFF_FAULT) st_next.fault_code = FAULT_NONE;

    // disable to enable restarts both timers
    if (chg_allowed && !st_reg.chg_allowed_d) begin
      st_next.safety_cnt = 32'h0; // R20
      st_next.topoff_cnt = 32'h0; // R8
      st_next.fault_code = FAULT_NONE;
      st_next.safety_expired = 1'b0; // R20
    end

    unique case (st_reg.fsm)
      CCS_IDLE: begin
        st_next.phase = PHASE_OFF; // R23
        if (chg_allowed && i_sense.ts_in_range && !st_reg.safety_expired
            && !st_reg.ctrl[CTRL_SW_OFF]) begin // R11
          st_next.fsm = CCS_CHARGE;
          st_next.phase = phase_of(i_sense); // R1
        end
      end
      CCS_CHARGE: begin
        st_next.phase = phase_of(i_sense); // R25
        if (!chg_allowed) begin
          st_next.fsm = CCS_IDLE;
        end else if (term_ok) begin
          st_next.fsm = CCS_TOPOFF;
          st_next.phase = PHASE_DONE; // R4
          st_next.topoff_sel = st_reg.timer_cfg[1:0]; // R9
          st_next.topoff_cnt = 32'h0; // R8
          ev_term = 1'b1; // R4
          ev_top_start = (st_reg.timer_cfg[1:0] != 2'h0); // R10
        end else if (st_reg.ctrl[CTRL_TMR_EN] && safety_limit_hit) begin // R18
          st_next.fsm = CCS_IDLE;
          st_next.fault_code = FAULT_TIMER; // R17
          st_next.safety_expired = 1'b1; // R17
          ev_safety = 1'b1; // R17
        end else if (tick && !safety_paused) begin
          st_next.safety_cnt = st_reg.safety_cnt + 32'h1; // R19 R20
        end
      end
      CCS_TOPOFF: begin
        st_next.phase = PHASE_DONE;
        if (!chg_allowed) begin
          st_next.fsm = CCS_IDLE;
        end else if (topoff_done) begin
          st_next.fsm = CCS_DONE;
          ev_top_end = (st_reg.topoff_sel != 2'h0); // R10
        end else if (tick && !safety_paused) begin
          st_next.topoff_cnt = st_reg.topoff_cnt + 32'h1; // R6
        end
      end
      CCS_DONE: begin
        st_next.phase = PHASE_DONE;
        if (!chg_allowed) begin
          st_next.fsm = CCS_IDLE;
        end else if (!i_sense.above_rechg) begin
          st_next.fsm = CCS_CHARGE; // recharge picks up new top-off setting
          st_next.safety_cnt = 32'h0;
          st_next.phase = phase_of(i_sense);
        end
      end
    endcase

    // boost thermistor monitor
    st_next.thermistor_fault_flag = boost_oor; // R14 R15

    // shipping mode: delayed or immediate switch opening
    if (!st_reg.ctrl[CTRL_SW_OFF]) begin
      st_next.ship_wait = 1'b0;
      st_next.ship_cnt = 32'h0;
      st_next.switch_open_ship = 1'b0;
    end else if (!st_reg.ctrl[CTRL_SHIP_DLY]) begin
      st_next.switch_open_ship = 1'b1; // R22
    end else if (!st_reg.switch_open_ship) begin
      st_next.ship_wait = 1'b1;
      if (tick) st_next.ship_cnt = st_reg.ship_cnt + 32'h1;
      if (st_reg.ship_cnt >= 32'(SHIP_TICKS)) st_next.switch_open_ship = 1'b1; // R22
    end

    // registered read data
    st_next.rdata = 16'h0;
    if (i_rd) begin
      unique case (i_addr)
        OFF_CTRL: st_next.rdata = {6'h0, st_reg.ctrl};
        OFF_TIMER: st_next.rdata = {8'h0, st_reg.timer_cfg};
        OFF_STATUS: st_next.rdata = {7'h0, st_reg.fsm == CCS_TOPOFF, // R7
                                     i_sense.vdpm, i_sense.idpm, // R21
                                     st_reg.thermistor_fault_flag, o_input_source_code, st_reg.phase};
        OFF_FAULT: st_next.rdata = {14'h0, st_reg.fault_code};
        default: st_next.rdata = 16'h0;
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      st_reg <= '{fsm: CCS_IDLE, ctrl: CTRL_RESET, timer_cfg: TIMER_RESET, default: '0};
    end else if (i_ce) begin
      st_reg <= st_next;
    end
  end

  // outputs to analog side and host
  always_comb begin
    o_drive.charge_on = (st_reg.fsm == CCS_CHARGE) & i_sense.ts_in_range; // R11
    o_drive.bat_switch_on = (st_reg.fsm == CCS_CHARGE) & ~st_reg.switch_open_ship; // R3 R22
    o_drive.warm_limit_41 = i_sense.ts_warm & st_reg.ctrl[CTRL_WARM_V]; // R12
    o_drive.cool_cut_20 = i_sense.ts_cool & st_reg.ctrl[CTRL_COOL_I]; // R13
    o_drive.cool_cut_half = i_sense.ts_cool & ~st_reg.ctrl[CTRL_COOL_I]; // R13
    o_drive.boost_run = i_boost_req & (~boost_oor
                        | (st_reg.timer_cfg[3:2] == BOOST_HOT_THRESHOLD_SELECT_OFF)); // R14 R15
    o_drive.short_current = (st_reg.fsm == CCS_CHARGE) & i_sense.bat_short; // R1
    o_input_source_code = !i_boost_req ? SRC_NONE
                          : (o_drive.boost_run ? SRC_BOOST : SRC_NONE); // R14
  end

  assign o_charge_phase_code = st_reg.phase;
  assign o_rdata = st_reg.rdata;
endmodule : ccs_sequencer

// *** test/ccs_checker.sv ***
/*
  port checker for the charge cycle sequencer, bound to its top module.
  assumes no bus access or pin change while i_ce is low, and comparator
  inputs synchronous to the clock.
*/
`timescale 1ns/100ps
module ccs_checker #(
  parameter int unsigned EVENT_WIDTH = ccs_pkg::EVENT_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_enable_pin_n,
  input wire logic i_boost_req,
  input wire ccs_pkg::ccs_sense_t i_sense,
  input wire logic [3:0] i_addr,
  input wire logic i_rd,
  input wire logic [15:0] o_rdata,
  input wire ccs_pkg::ccs_drive_t o_drive,
  input wire logic [1:0] o_charge_phase_code,
  input wire logic [2:0] o_input_source_code,
  input wire logic o_event
);
  import ccs_pkg::*;
  int unsigned ev_len;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  // length of the current event pulse
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      ev_len <= 0;
    end else begin
      ev_len <= o_event ? ev_len + 1 : 0;
    end
  end
  a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 16'h0)
    else $error("read data outside read answer");
  a_rdata_unmapped: assert property ($past(i_rd) && $past(i_addr) > 4'h3 |-> o_rdata == 16'h0)
    else $error("unmapped read not zero");
  a_source_code: assert property (i_boost_req && i_sense.ts_boost_ok |-> o_input_source_code == SRC_BOOST)
    else $error("source code not boost while boost runs");
  a_source_none: assert property (!i_boost_req |-> o_input_source_code == SRC_NONE)
    else $error("source code set without boost");
  a_boost_idle: assert property (!i_boost_req |-> !o_drive.boost_run)
    else $error("boost runs unrequested");
  a_ts_suspend: assert property (!i_sense.ts_in_range |-> !o_drive.charge_on)
    else $error("charging out of temperature range");
  a_warm_limit: assert property (o_drive.warm_limit_41 |-> i_sense.ts_warm)
    else $error("warm limit outside warm zone");
  a_cool_cut: assert property (o_drive.cool_cut_20 || o_drive.cool_cut_half |-> i_sense.ts_cool)
    else $error("cool cut outside cool zone");
  a_short_current: assert property (o_drive.short_current |-> i_sense.bat_short)
    else $error("short current above short level");
  a_event_width: assert property ($fell(o_event) |-> ev_len >= EVENT_WIDTH)
    else $error("event pulse too short");
  a_phase_off: assert property ($rose(i_enable_pin_n) |-> ##[1:3] o_charge_phase_code == PHASE_OFF)
    else $error("phase not off after disable");
  // main scenarios reached
  c_event: cover property ($rose(o_event));
  c_done: cover property (o_charge_phase_code == PHASE_DONE);
  c_boost: cover property (o_drive.boost_run);
  c_warm: cover property (o_drive.warm_limit_41);
endmodule : ccs_checker

bind ccs_sequencer ccs_checker #(.EVENT_WIDTH(EVENT_WIDTH)) chk_u (.i_clk(i_clk), .i_reset(i_reset),
  .i_enable_pin_n(i_enable_pin_n), .i_boost_req(i_boost_req), .i_sense(i_sense), .i_addr(i_addr),
  .i_rd(i_rd), .o_rdata(o_rdata), .o_drive(o_drive), .o_charge_phase_code(o_charge_phase_code),
  .o_input_source_code(o_input_source_code), .o_event(o_event));

// *** test/ccs_host_model.sv ***
/*
  host side model: counts event pulses arriving from the sequencer.
  assumes pulses are at least one clock long.
*/
`timescale 1ns/100ps
module ccs_host_model (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_event,
  output int o_count
);
  logic prev_reg;
  // count rising edges of the event line
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      prev_reg <= 1'b0;
      o_count <= 0;
    end else begin
      prev_reg <= i_event;
      if (i_event && !prev_reg) begin
        o_count <= o_count + 1;
      end
    end
  end
endmodule : ccs_host_model

// *** test/charge_cycle_sequencer_test.sv ***
/*
  self-checking bench for the charge cycle sequencer with shortened timers.
  assumes the register map and status layout of the sequencer package.
*/
`timescale 1ns/100ps
module charge_cycle_sequencer_test;
  import ccs_pkg::*;
  logic i_clk, i_reset, i_ce, i_enable_pin_n, i_boost_req, i_wr, i_rd, o_event;
  logic [3:0] i_addr;
  logic [15:0] i_wdata, o_rdata, v;
  logic [1:0] o_charge_phase_code;
  logic [2:0] o_input_source_code;
  ccs_sense_t i_sense;
  ccs_drive_t o_drive;
  int ev_count, n_errors, check_count, e0, k;
  realtime t0;
  ccs_sequencer #(.TICK_DIV(4), .LOWBAT_TICKS(8), .HOUR_TICKS(20), .TOPOFF_UNIT_TICKS(5),
    .SHIP_TICKS(5), .EVENT_WIDTH(3)) dut_u (.i_clk(i_clk), .i_reset(i_reset), .i_ce(i_ce),
    .i_enable_pin_n(i_enable_pin_n), .i_boost_req(i_boost_req), .i_sense(i_sense), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_drive(o_drive),
    .o_charge_phase_code(o_charge_phase_code), .o_input_source_code(o_input_source_code), .o_event(o_event));
  ccs_host_model host_u (.i_clk(i_clk), .i_reset(i_reset), .i_event(o_event), .o_count(ev_count));
  // 25 mhz clock
  always #20 i_clk = ~i_clk;
  task chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task chk_min(input int got, input int lo);
    check_count++;
    if (got < lo) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h min=%h", $time, got, lo);
    end
  endtask : chk_min
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr
  task rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    // take the answer mid-cycle, hand back control on a rising edge
    @(negedge i_clk);
    d = o_rdata;
    @(posedge i_clk);
  endtask : rd
  // poll a register until the masked value matches, bounded
  task waitr(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
    logic [15:0] r;
    r = ~e;
    for (int j = 0; j < 300 && (r & m) !== e; j++) rd(a, r);
    chk(r & m, e);
    if ((r & m) !== e) summarize();
  endtask : waitr
  task toggle_pin();
    @(posedge i_clk);
    i_enable_pin_n <= 1'b1;
    repeat (5) @(posedge i_clk);
    i_enable_pin_n <= 1'b0;
  endtask : toggle_pin
  task t_regs();
    rd(OFF_CTRL, v);
    chk(v, {6'h0, CTRL_RESET});
    rd(OFF_TIMER, v);
    chk(v, {8'h0, TIMER_RESET});
    wr(4'h9, 16'hffff);
    rd(4'h9, v);
    chk(v, 16'h0);
    chk({14'h0, o_charge_phase_code}, {14'h0, PHASE_OFF});
    $display("test regs done");
  endtask : t_regs
  task t_phase();
    @(posedge i_clk);
    i_sense.ts_in_range <= 1'b1;
    i_sense.bat_short <= 1'b1;
    i_sense.bat_low <= 1'b1;
    i_enable_pin_n <= 1'b0;
    waitr(OFF_STATUS, 16'h3, {14'h0, PHASE_PRE});
    chk({15'h0, o_drive.short_current}, 16'h1);
    i_sense.bat_short <= 1'b0;
    repeat (10) @(posedge i_clk);
    chk({14'h0, o_charge_phase_code}, {14'h0, PHASE_PRE});
    i_sense.ts_warm <= 1'b1;
    wr(OFF_CTRL, 16'h03f);
    @(posedge i_clk);
    chk({15'h0, o_drive.warm_limit_41}, 16'h1);
    i_sense.ts_warm <= 1'b0;
    i_sense.ts_cool <= 1'b1;
    i_sense.bat_low <= 1'b0;
    waitr(OFF_STATUS, 16'h3, {14'h0, PHASE_FAST});
    chk({14'h0, o_drive.cool_cut_20, o_drive.cool_cut_half}, 16'h2);
    wr(OFF_CTRL, 16'h00f);
    @(posedge i_clk);
    chk({14'h0, o_drive.cool_cut_20, o_drive.cool_cut_half}, 16'h1);
    i_sense.ts_cool <= 1'b0;
    $display("test phase done");
  endtask : t_phase
  task t_term();
    e0 = ev_count;
    @(posedge i_clk);
    i_sense.above_rechg <= 1'b1;
    i_sense.below_iterm <= 1'b1;
    i_sense.idpm <= 1'b1;
    i_sense.vdpm <= 1'b1;
    repeat (20) @(posedge i_clk);
    rd(OFF_STATUS, v);
    chk(v & 16'h0c3, 16'h0c2);
    i_sense.idpm <= 1'b0;
    i_sense.vdpm <= 1'b0;
    i_sense.therm <= 1'b1;
    repeat (10) @(posedge i_clk);
    chk({14'h0, o_charge_phase_code}, {14'h0, PHASE_FAST});
    i_sense.therm <= 1'b0;
    waitr(OFF_STATUS, 16'h103, 16'h103);
    chk_min(ev_count, e0 + 1);
    waitr(OFF_STATUS, 16'h103, 16'h003);
    chk({15'h0, o_drive.bat_switch_on}, 16'h0);
    chk_min(ev_count, e0 + 2);
    $display("test term done");
  endtask : t_term
  task t_noterm_ship();
    i_sense.above_rechg <= 1'b0;
    wr(OFF_CTRL, 16'h00d);
    toggle_pin();
    i_sense.above_rechg <= 1'b1;
    waitr(OFF_STATUS, 16'h3, 16'h2);
    repeat (60) @(posedge i_clk);
    chk({14'h0, o_charge_phase_code}, {14'h0, PHASE_FAST});
    chk({15'h0, o_drive.bat_switch_on}, 16'h1);
    wr(OFF_CTRL, 16'h04d);
    repeat (2) @(posedge i_clk);
    chk({15'h0, o_drive.bat_switch_on}, 16'h0);
    wr(OFF_CTRL, 16'h00d);
    wr(OFF_CTRL, 16'h0cd);
    repeat (2) @(posedge i_clk);
    chk({15'h0, o_drive.bat_switch_on}, 16'h1);
    // clock enable low must freeze the shipping delay count
    i_ce <= 1'b0;
    repeat (100) @(posedge i_clk);
    chk({15'h0, o_drive.bat_switch_on}, 16'h1);
    i_ce <= 1'b1;
    for (k = 0; k < 200 && o_drive.bat_switch_on !== 1'b0; k++) @(posedge i_clk);
    chk({15'h0, o_drive.bat_switch_on}, 16'h0);
    chk_min(k, 12);
    wr(OFF_CTRL, 16'h00d);
    $display("test noterm ship done");
  endtask : t_noterm_ship
  task t_safety();
    i_sense.bat_lowv <= 1'b1;
    i_sense.bat_low <= 1'b1;
    toggle_pin();
    // a fault pauses the safety count well past its limit
    i_sense.fault <= 1'b1;
    repeat (60) @(posedge i_clk);
    rd(OFF_FAULT, v);
    chk(v, 16'h0);
    i_sense.fault <= 1'b0;
    e0 = ev_count;
    t0 = $realtime;
    waitr(OFF_FAULT, 16'h3, {14'h0, FAULT_TIMER});
    chk({15'h0, ($realtime - t0) < 4000.0}, 16'h1);
    chk_min(ev_count, e0 + 1);
    rd(OFF_FAULT, v);
    chk(v, 16'h0);
    wr(OFF_CTRL, 16'h009);
    toggle_pin();
    repeat (150) @(posedge i_clk);
    rd(OFF_FAULT, v);
    chk(v, 16'h0);
    $display("test safety done");
  endtask : t_safety
  task t_boost();
    i_enable_pin_n <= 1'b1;
    i_boost_req <= 1'b1;
    i_sense.ts_boost_ok <= 1'b1;
    waitr(OFF_STATUS, 16'h03c, 16'h01c);
    i_sense.ts_boost_ok <= 1'b0;
    waitr(OFF_STATUS, 16'h03c, 16'h020);
    wr(OFF_TIMER, 16'h04e);
    waitr(OFF_STATUS, 16'h03c, 16'h03c);
    i_sense.ts_boost_ok <= 1'b1;
    waitr(OFF_STATUS, 16'h03c, 16'h01c);
    i_boost_req <= 1'b0;
    wr(OFF_CTRL, 16'h100);
    rd(OFF_CTRL, v);
    chk(v, {6'h0, CTRL_RESET});
    rd(OFF_TIMER, v);
    chk(v, {8'h0, TIMER_RESET});
    $display("test boost done");
  endtask : t_boost
  task summarize();
    $display("checks=%0d errors=%0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : summarize
  // reset, then run every scenario in turn
  initial begin
    i_clk = 1'b0;
    i_reset = 1'b1;
    i_ce = 1'b1;
    i_enable_pin_n = 1'b1;
    i_boost_req = 1'b0;
    i_sense = '0;
    i_addr = 4'h0;
    i_wdata = 16'h0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    n_errors = 0;
    check_count = 0;
    repeat (20) @(posedge i_clk);
    i_reset <= 1'b0;
    t_regs();
    t_phase();
    t_term();
    t_noterm_ship();
    t_safety();
    t_boost();
    summarize();
  end
endmodule : charge_cycle_sequencer_test
